// ---- ett_top.sv ----
/*
 Event triggered data transfer engine with AHB-Lite register slave and
 a single-beat memory master port.
 Assumes m_ack is a one-cycle pulse answering a held m_req, and that
 software builds the vector table and records before enabling sources.
*/
`timescale 1ns/1ps
`default_nettype none
module ett_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Peripheral requests
    input wire logic [ett_pkg::ETT_NIRQ-1:0] irq_i,
    // Memory master
    output logic m_req,
    output logic m_we,
    output logic [31:0] m_addr,
    output logic [2:0] m_size,
    output logic [31:0] m_wdata,
    input wire logic [31:0] m_rdata,
    input wire logic m_ack
);
    import ett_pkg::*;

    typedef struct packed {
        ett_state_t st;
        logic en;
        logic full;
        logic [31:0] vbase;
        logic [ETT_NCH-1:0] acten;
        logic [ETT_NCH-1:0] pend;
        logic [ETT_NCH-1:0] done;
        logic [3:0] ch;
        logic [31:0] info;
        logic [1:0] wi;
        logic [1:0] size;
        logic blk;
        logic sinc;
        logic dinc;
        logic [7:0] bsz;
        logic [31:0] src;
        logic [31:0] dst;
        logic [15:0] cnt;
        logic [7:0] units;
        logic [31:0] data;
        logic a_vld;
        logic a_wr;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
        logic m_req;
        logic m_we;
        logic [31:0] m_addr;
        logic [2:0] m_size;
        logic [31:0] m_wdata;
    } ett_main_t;

    ett_main_t q;
    ett_main_t d;
    logic [ETT_NIRQ-1:0] irq_rise;

    ett_req_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .irq_i(irq_i),
        .rise_o(irq_rise)
    );

    function automatic logic [31:0] ett_amask(input logic [31:0] a,
                                              input logic full);
        ett_amask = full ? a : (a & ETT_SHORT_MASK);
    endfunction

    logic [3:0] sel;
    logic found;
    logic sw_set;
    logic [ETT_NCH-1:0] ready;
    logic [ETT_NCH-1:0] req_set;
    logic [ETT_NCH-1:0] pend_clr;
    logic [ETT_NCH-1:0] act_clr;
    logic [ETT_NCH-1:0] done_set;
    logic [ETT_NCH-1:0] done_w1c;
    logic [31:0] inc;
    logic [31:0] nsrc;
    logic [31:0] ndst;
    logic [1:0] nwi;

    always_comb begin
        d = q;
        sel = 4'h0;
        found = 1'b0;
        sw_set = 1'b0;
        pend_clr = '0;
        act_clr = '0;
        done_set = '0;
        done_w1c = '0;
        nwi = q.wi + 2'h1;
        inc = 32'h1 << q.size;
        nsrc = ett_amask(q.sinc ? q.src + inc : q.src, q.full);
        ndst = ett_amask(q.dinc ? q.dst + inc : q.dst, q.full);

        // Lowest ready channel wins; channels are otherwise independent
        ready = q.pend & q.acten; // see R1
        for (int i = ETT_NCH - 1; i >= 0; i--) begin
            if (ready[i]) begin
                sel = 4'(i);
                found = 1'b1;
            end
        end

        // Register slave, zero wait states
        d.hready = 1'b1;
        d.hresp = 1'b0;
        d.a_vld = hsel && htrans[1] && hready;
        d.a_wr = hwrite;
        d.a_addr = haddr[7:0];
        if (q.a_vld && q.a_wr) begin
            if (q.a_addr == ETT_OFS_CTRL) begin
                d.en = hwdata[ETT_CTRL_EN];
                d.full = hwdata[ETT_CTRL_FULL]; // see R11
            end else if (q.a_addr == ETT_OFS_VBASE) begin
                d.vbase = hwdata; // see R12
            end else if (q.a_addr == ETT_OFS_ACTEN) begin
                d.acten = hwdata[ETT_NCH-1:0]; // see R8
            end else if (q.a_addr == ETT_OFS_SWTRIG) begin
                sw_set = hwdata[ETT_SWTRIG_GO]; // see R9
            end else if (q.a_addr == ETT_OFS_DONE) begin
                done_w1c = hwdata[ETT_NCH-1:0];
            end
        end
        d.hrdata = 32'h00000000;
        if (hsel && htrans[1] && hready && !hwrite) begin
            if (haddr[7:0] == ETT_OFS_CTRL) begin
                d.hrdata = {30'h00000000, q.full, q.en};
            end else if (haddr[7:0] == ETT_OFS_VBASE) begin
                d.hrdata = q.vbase;
            end else if (haddr[7:0] == ETT_OFS_ACTEN) begin
                d.hrdata = {23'h000000, q.acten};
            end else if (haddr[7:0] == ETT_OFS_STATUS) begin
                d.hrdata = {7'h00, q.pend, 8'h00, q.ch, 3'h0,
                            q.st != ETT_IDLE};
            end else if (haddr[7:0] == ETT_OFS_DONE) begin
                d.hrdata = {23'h000000, q.done};
            end
        end

        // Transfer engine
        case (q.st)
            ETT_IDLE: begin
                if (q.en && found) begin // see R7
                    d.ch = sel;
                    pend_clr[sel] = 1'b1;
                    d.st = ETT_VEC;
                    d.m_req = 1'b1;
                    d.m_we = 1'b0;
                    d.m_size = {1'b0, ETT_SZ_WORD};
                    d.m_addr = ett_amask(q.vbase + {26'h0, sel, 2'b00},
                                         q.full); // see R12
                end
            end
            ETT_VEC: begin
                if (m_ack) begin
                    d.info = ett_amask(m_rdata, q.full);
                    d.wi = ETT_W_MODE;
                    d.st = ETT_INFO;
                    d.m_addr = ett_amask(m_rdata, q.full);
                end
            end
            ETT_INFO: begin
                if (m_ack) begin
                    if (q.wi == ETT_W_MODE) begin
                        d.size = m_rdata[ETT_F_SIZE_LSB +: 2]; // see R4
                        d.blk = m_rdata[ETT_F_BLK];
                        d.sinc = m_rdata[ETT_F_SINC];
                        d.dinc = m_rdata[ETT_F_DINC];
                        d.bsz = m_rdata[ETT_F_BSZ_LSB +: 8]; // see R5
                    end else if (q.wi == ETT_W_SRC) begin
                        d.src = ett_amask(m_rdata, q.full); // see R10
                    end else if (q.wi == ETT_W_DST) begin
                        d.dst = ett_amask(m_rdata, q.full); // see R10
                    end else begin
                        d.cnt = m_rdata[ETT_F_CNT_LSB +: 16]; // see R6
                    end
                    if (q.wi == ETT_W_CNT) begin
                        // Block mode keeps bsz more units to move
                        d.units = q.blk ? q.bsz : 8'h00; // see R3
                        d.st = ETT_RD;
                        d.m_addr = q.src;
                        d.m_size = {1'b0, q.size};
                    end else begin
                        d.wi = nwi;
                        d.m_addr = q.info + {28'h0, nwi, 2'b00};
                    end
                end
            end
            ETT_RD: begin
                if (m_ack) begin
                    d.data = m_rdata;
                    d.st = ETT_WR;
                    d.m_we = 1'b1;
                    d.m_addr = q.dst;
                    d.m_wdata = m_rdata;
                end
            end
            ETT_WR: begin
                if (m_ack) begin
                    d.src = nsrc;
                    d.dst = ndst;
                    if (q.units != 8'h00) begin
                        d.units = q.units - 8'h01; // see R3
                        d.st = ETT_RD;
                        d.m_we = 1'b0;
                        d.m_addr = nsrc;
                    end else begin
                        // One unit per request in normal mode
                        d.cnt = q.cnt - 16'h0001; // see R2
                        d.st = ETT_WB;
                        d.wi = ETT_W_SRC;
                        d.m_size = {1'b0, ETT_SZ_WORD};
                        d.m_addr = q.info + {28'h0, ETT_W_SRC, 2'b00};
                        d.m_wdata = nsrc; // see R13
                    end
                end
            end
            ETT_WB: begin
                if (m_ack) begin
                    d.wi = nwi;
                    d.m_addr = q.info + {28'h0, nwi, 2'b00};
                    if (q.wi == ETT_W_SRC) begin
                        d.m_wdata = q.dst;
                    end else if (q.wi == ETT_W_DST) begin
                        d.m_wdata = {16'h0000, q.cnt};
                    end else begin
                        d.m_req = 1'b0;
                        d.m_we = 1'b0;
                        d.st = ETT_IDLE;
                        // Zero left ends it; a start value of 0 gives 65,536
                        if (q.cnt == 16'h0000) begin // see R13
                            act_clr[q.ch] = 1'b1;
                            done_set[q.ch] = 1'b1;
                        end
                    end
                end
            end
            default: begin
                d.st = ETT_IDLE;
                d.m_req = 1'b0;
            end
        endcase

        // New requests beat a clear in the same cycle
        req_set = {sw_set, irq_rise} & q.acten; // see R8
        d.pend = (q.pend & ~pend_clr) | req_set; // see R9
        d.acten = d.acten & ~act_clr;
        d.done = (q.done & ~done_w1c) | done_set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.hready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hreadyout = q.hready;
    assign hrdata = q.hrdata;
    assign hresp = q.hresp;
    assign m_req = q.m_req;
    assign m_we = q.m_we;
    assign m_addr = q.m_addr;
    assign m_size = q.m_size;
    assign m_wdata = q.m_wdata;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_start;
        q.st == ETT_IDLE && d.st == ETT_VEC;
    endsequence

    sequence s_last_unit;
        q.st == ETT_WR && m_ack && q.units == 8'h00;
    endsequence

    sequence s_seq_end;
        q.st == ETT_WB && q.wi == ETT_W_CNT && m_ack && q.cnt == 16'h0000;
    endsequence

    chk_req_held: assert property ( // see R10
        m_req && !m_ack |=> m_req && $stable(m_addr) && $stable(m_we))
        else $error("request changed before ack");

    chk_start_enabled: assert property ( // see R7
        s_start |-> q.en && q.acten[d.ch] && q.pend[d.ch])
        else $error("start without enabled pending source");

    chk_gate_pend: assert property ( // see R8
        !q.acten[0] && !q.pend[0] |=> !q.pend[0])
        else $error("disabled source became pending");

    chk_sw_request: assert property ( // see R9
        q.a_vld && q.a_wr && q.a_addr == ETT_OFS_SWTRIG && hwdata[0] &&
        q.acten[ETT_SW_CH] |=> q.pend[ETT_SW_CH])
        else $error("software request lost");

    chk_unit_size: assert property ( // see R4
        m_req |-> m_size <= {1'b0, ETT_SZ_WORD})
        else $error("illegal unit size");

    chk_short_range: assert property ( // see R11
        m_req && !q.full && $stable(q.full) |-> m_addr[31:24] == 8'h00)
        else $error("short mode address above 16 MB");

    chk_vec_fetch: assert property ( // see R12
        q.st == ETT_VEC && m_req |->
        m_addr == ett_amask(q.vbase + {26'h0, q.ch, 2'b00}, q.full) && !m_we)
        else $error("vector fetch at wrong address");

    chk_normal_single: assert property ( // see R2
        q.st == ETT_WR && m_ack && !q.blk |=> q.st == ETT_WB)
        else $error("normal mode moved more than one unit");

    chk_block_more: assert property ( // see R3 R5
        q.st == ETT_WR && m_ack && q.units != 8'h00 |=>
        q.st == ETT_RD && q.units == $past(q.units) - 8'h01)
        else $error("block unit count wrong");

    chk_count_dec: assert property ( // see R6
        s_last_unit |=> q.st == ETT_WB && q.cnt == $past(q.cnt) - 16'h0001)
        else $error("transfer count not decremented");

    chk_end_disable: assert property ( // see R13
        s_seq_end |=> q.st == ETT_IDLE && q.done[$past(q.ch)] &&
        !m_req ##1 !q.acten[$past(q.ch, 2)])
        else $error("exhausted channel still enabled");
endmodule
`default_nettype wire

// ---- ett_pkg.sv ----
/*
 Constants, field layouts and engine states for the event triggered
 data transfer block. Assumes one clock domain (hclk) and an AHB-Lite
 register port on the same clock.
*/
// What this block does
// R1 - One transfer channel per request source allowed to start transfers.
// R2 - Normal mode: one request moves one data unit, then waits again.
// R3 - Block mode: one request moves a whole block of consecutive units.
// R4 - Each unit is a byte, halfword or word, chosen per transfer record.
// R5 - Block size is programmable from 1 to 256 units.
// R6 - Transfer counter allows up to 65,536 transfers per sequence.
// R7 - A transfer starts only on a request from an enabled source.
// R8 - Software sets a per-source enable bit; only enabled sources are served.
// R9 - Peripheral requests and a software request can both start transfers.
// R10 - Source and destination may lie anywhere in the address space.
// R11 - Short-address mode spans 16 MB, full-address mode spans 4 GB.
// R12 - Transfer records are found through a vector table in RAM.
// R13 - Count and addresses written back; sequence ends when count runs out.
`default_nettype none
package ett_pkg;
    localparam int unsigned ETT_NIRQ = 8;
    localparam int unsigned ETT_NCH = 9;
    localparam logic [3:0] ETT_SW_CH = 4'h8;

    // Register byte offsets
    localparam logic [7:0] ETT_OFS_CTRL = 8'h00;
    localparam logic [7:0] ETT_OFS_VBASE = 8'h04;
    localparam logic [7:0] ETT_OFS_ACTEN = 8'h08;
    localparam logic [7:0] ETT_OFS_SWTRIG = 8'h0C;
    localparam logic [7:0] ETT_OFS_STATUS = 8'h10;
    localparam logic [7:0] ETT_OFS_DONE = 8'h14;

    // Control bits
    localparam int unsigned ETT_CTRL_EN = 0;
    localparam int unsigned ETT_CTRL_FULL = 1;
    localparam int unsigned ETT_SWTRIG_GO = 0;

    // Mode and count word fields of a transfer record
    localparam int unsigned ETT_F_SIZE_LSB = 0;
    localparam int unsigned ETT_F_BLK = 2;
    localparam int unsigned ETT_F_SINC = 3;
    localparam int unsigned ETT_F_DINC = 4;
    localparam int unsigned ETT_F_BSZ_LSB = 8;
    localparam int unsigned ETT_F_CNT_LSB = 0;

    // Word index inside a transfer record
    localparam logic [1:0] ETT_W_MODE = 2'h0;
    localparam logic [1:0] ETT_W_SRC = 2'h1;
    localparam logic [1:0] ETT_W_DST = 2'h2;
    localparam logic [1:0] ETT_W_CNT = 2'h3;

    localparam logic [1:0] ETT_SZ_WORD = 2'h2;
    localparam logic [31:0] ETT_SHORT_MASK = 32'h00FFFFFF;

    typedef enum logic [2:0] {
        ETT_IDLE,
        ETT_VEC,
        ETT_INFO,
        ETT_RD,
        ETT_WR,
        ETT_WB
    } ett_state_t;
endpackage
`default_nettype wire

// ---- ett_req_sync.sv ----
/*
 Request synchroniser: brings the peripheral request lines into hclk
 and turns each rising level into a one-cycle pulse.
 Assumes requests are levels from outside the hclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ett_req_sync (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Raw requests
    input wire logic [ett_pkg::ETT_NIRQ-1:0] irq_i,
    // Request pulses
    output logic [ett_pkg::ETT_NIRQ-1:0] rise_o
);
    import ett_pkg::*;

    typedef struct packed {
        logic [ETT_NIRQ-1:0] s1;
        logic [ETT_NIRQ-1:0] s2;
        logic [ETT_NIRQ-1:0] s3;
        logic [ETT_NIRQ-1:0] rise;
    } ett_sync_t;

    ett_sync_t q;
    ett_sync_t d;

    always_comb begin
        d = q;
        d.s1 = irq_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Edge taken between the second and third stage only
        d.rise = q.s2 & ~q.s3;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise_o = q.rise;
endmodule
`default_nettype wire

// ---- ett_mem_model.sv ----
/*
 Memory on the engine's master port: 1 KB of words, upper address bits
 alias. Assumes m_req is held until m_ack; lat sets the wait cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module ett_mem_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Master port
    input wire logic m_req,
    input wire logic m_we,
    input wire logic [31:0] m_addr,
    input wire logic [2:0] m_size,
    input wire logic [31:0] m_wdata,
    output logic [31:0] m_rdata,
    output logic m_ack,
    // Bench control
    input wire logic [3:0] lat,
    input wire logic clr_hi,
    output logic hi_hit
);
    logic [31:0] mem [256];
    logic [3:0] cnt_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            m_ack <= 1'b0;
            cnt_q <= 4'h0;
            m_rdata <= 32'h0;
            hi_hit <= 1'b0;
        end else if (m_ack || !m_req) begin
            m_ack <= 1'b0;
            cnt_q <= 4'h0;
            // Stale data flips every cycle
            m_rdata <= ~m_rdata;
            if (clr_hi)
                hi_hit <= 1'b0;
        end else if (cnt_q != lat) begin
            cnt_q <= cnt_q + 4'h1;
            m_rdata <= ~m_rdata;
        end else begin
            // Any address is served
            m_ack <= 1'b1;
            m_rdata <= mem[m_addr[9:2]];
            if (m_addr[31:24] != 8'h00)
                hi_hit <= 1'b1;
            for (int b = 0; b < 4; b++) begin
                if (m_we && b >= m_addr[1:0] &&
                    b < m_addr[1:0] + (1 << m_size))
                    mem[m_addr[9:2]][8*b +: 8] <= m_wdata[8*b +: 8];
            end
        end
    end
endmodule
`default_nettype wire

// ---- ett_top_tb.sv ----
/*
 Self-checking bench for the transfer engine.
 Assumes the memory model answers on the master port.
*/
`timescale 1ns/1ps
`default_nettype none
module ett_top_tb;
    import ett_pkg::*;
    typedef struct {
        int ch;
        logic [31:0] mode;
        logic [15:0] cnt;
        int acts;
        logic [3:0] lat;
        logic en;
    } ett_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hresp, m_req, m_we, m_ack, hi_hit;
    logic [31:0] hrdata, m_addr, m_wdata, m_rdata, rv;
    logic [7:0] irq_i = 8'h00;
    logic [2:0] m_size;
    logic [3:0] lat = 4'h0;
    logic clr_hi = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    ett_row_t rows [7] = '{
        '{0, 32'h0000001A, 16'h2, 2, 4'h0, 1'b1},
        '{3, 32'h00000018, 16'h1, 1, 4'h3, 1'b1},
        '{5, 32'h0000031D, 16'h1, 1, 4'h2, 1'b1},
        '{1, 32'h0000FF1C, 16'h1, 1, 4'h0, 1'b1},
        '{2, 32'h0000001A, 16'h0, 1, 4'h1, 1'b1},
        '{4, 32'h0000001A, 16'h1, 1, 4'h0, 1'b0},
        '{8, 32'h0000001E, 16'h2, 2, 4'h1, 1'b1}
    };
    always #5 hclk = ~hclk;
    ett_top ett_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hrdata(hrdata), .hresp(hresp), .irq_i(irq_i), .m_req(m_req),
        .m_we(m_we), .m_addr(m_addr), .m_size(m_size),
        .m_wdata(m_wdata), .m_rdata(m_rdata), .m_ack(m_ack));
    ett_mem_model ett_mem_model_inst (.hclk(hclk), .hresetn(hresetn),
        .m_req(m_req), .m_we(m_we), .m_addr(m_addr), .m_size(m_size),
        .m_wdata(m_wdata), .m_rdata(m_rdata), .m_ack(m_ack),
        .lat(lat), .clr_hi(clr_hi), .hi_hit(hi_hit));
    task automatic end_sim();
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk32(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rdy_wait();
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            miscompares++;
            end_sim();
        end
    endtask
    // One single word transfer, then one idle cycle
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        rdy_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy_wait();
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic trig(input int ch);
        if (ch == 8)
            ahb(1'b1, ETT_OFS_SWTRIG, 32'h1, rv);
        else begin
            irq_i[ch] <= 1'b1;
            repeat (3) @(posedge hclk);
            irq_i[ch] <= 1'b0;
            @(posedge hclk);
        end
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        int n = 0;
        repeat (10) @(posedge hclk);
        do begin
            ahb(1'b0, ETT_OFS_STATUS, 32'h0, s);
            n++;
        end while ((s[0] !== 1'b0 || s[24:16] !== 9'h0) && n < 500);
        if (s[0] !== 1'b0 || s[24:16] !== 9'h0) begin
            miscompares++;
            end_sim();
        end
    endtask
    function automatic logic [31:0] pat(input int k);
        return {8'(k), 8'hC3, 8'(k + 64), 8'h5A};
    endfunction
    task automatic run_row(input ett_row_t r);
        int nb;
        logic [31:0] rec, e, g;
        logic [15:0] left;
        nb = r.en ? (r.acts * (r.mode[2] ? r.mode[15:8] + 1 : 1))
            << r.mode[1:0] : 0;
        left = r.en ? 16'(r.cnt - r.acts) : r.cnt;
        rec = 32'h100 + 16 * r.ch;
        lat <= r.lat;
        // Vector entry and record built first
        ett_mem_model_inst.mem[r.ch] <= rec;
        ett_mem_model_inst.mem[rec[9:2]] <= r.mode;
        ett_mem_model_inst.mem[rec[9:2] + 1] <= 32'h200;
        ett_mem_model_inst.mem[rec[9:2] + 2] <= 32'h300;
        ett_mem_model_inst.mem[rec[9:2] + 3] <= {16'h0, r.cnt};
        for (int k = 0; k < 64; k++)
            ett_mem_model_inst.mem[192 + k] <= 32'h0;
        ahb(1'b1, ETT_OFS_DONE, 32'h1FF, rv);
        ahb(1'b1, ETT_OFS_ACTEN, {31'h0, r.en} << r.ch, rv);
        repeat (r.acts) begin
            trig(r.ch);
            wait_idle();
        end
        for (int k = 0; k < 64; k++) begin
            e = (4 * k + 4 <= nb) ? pat(k) : (4 * k < nb) ?
                pat(k) & ~(32'hFFFFFFFF << 8 * (nb - 4 * k)) : 32'h0;
            g = ett_mem_model_inst.mem[192 + k];
            chk32("dst", e, g);
        end
        g = ett_mem_model_inst.mem[rec[9:2] + 1];
        chk32("src_wb", 32'h200 + nb, g);
        g = ett_mem_model_inst.mem[rec[9:2] + 2];
        chk32("dst_wb", 32'h300 + nb, g);
        g = ett_mem_model_inst.mem[rec[9:2] + 3];
        chk32("cnt_wb", {16'h0, left}, g);
        ahb(1'b0, ETT_OFS_DONE, 32'h0, rv);
        e = {31'h0, r.en && left == 16'h0} << r.ch;
        chk32("done", e, rv);
        ahb(1'b0, ETT_OFS_ACTEN, 32'h0, rv);
        e = {31'h0, r.en && left != 16'h0} << r.ch;
        chk32("acten", e, rv);
        ahb(1'b1, ETT_OFS_ACTEN, 32'h0, rv);
    endtask
    initial begin
        repeat (100000) @(posedge hclk);
        miscompares++;
        end_sim();
    end
    initial begin
        for (int k = 0; k < 64; k++)
            ett_mem_model_inst.mem[128 + k] = pat(k);
        repeat (5) @(posedge hclk);
        chk32("rst_rdy", 32'h1, {31'h0, hready});
        chk32("rst_out", 32'h0, hrdata | {31'h0, m_req});
        hresetn <= 1'b1;
        ahb(1'b1, 8'h18, 32'hFFFFFFFF, rv);
        foreach (ofs[i]) begin
            ahb(1'b0, ofs[i], 32'h0, rv);
            chk32("rst_reg", 32'h0, rv);
        end
        ahb(1'b1, ETT_OFS_VBASE, 32'hAB000000, rv);
        ahb(1'b1, ETT_OFS_CTRL, 32'h1, rv);
        clr_hi <= 1'b1;
        @(posedge hclk);
        clr_hi <= 1'b0;
        foreach (rows[i])
            run_row(rows[i]);
        chk32("short", 32'h0, {31'h0, hi_hit});
        ahb(1'b1, ETT_OFS_CTRL, 32'h3, rv);
        run_row(rows[6]);
        chk32("full", 32'h1, {31'h0, hi_hit});
        chk32("hresp", 32'h0, {31'h0, hresp});
        // Reset in mid-transfer: m_req drops at once, hready stays high, registers clear
        lat <= 4'hF;
        ahb(1'b1, ETT_OFS_ACTEN, 32'h100, rv);
        ahb(1'b1, ETT_OFS_SWTRIG, 32'h1, rv);
        repeat (3) @(posedge hclk);
        chk32("mid_req", 32'h1, {31'h0, m_req});
        hresetn <= 1'b0;
        @(posedge hclk);
        chk32("mid_rst", 32'h1, {30'h0, m_req, hready});
        hresetn <= 1'b1;
        ahb(1'b0, ETT_OFS_STATUS, 32'h0, rv);
        chk32("rst_status", 32'h0, rv);
        ahb(1'b0, ETT_OFS_ACTEN, 32'h0, rv);
        chk32("rst_acten", 32'h0, rv);
        ahb(1'b0, ETT_OFS_CTRL, 32'h0, rv);
        chk32("rst_ctrl", 32'h0, rv);
        end_sim();
    end
endmodule
`default_nettype wire
